// >>> hw/aed_decoder.v
// quadrature a/b/n encoder decoder with apb register access
// assumes apb master on pclk; encoder pins synchronised inside, pole pairs synchronous to pclk
`timescale 1ns/1ps
`include "aed_map.vh"

module aed_decoder #(
  parameter CNT_W = 24
) (
  // apb
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // encoder
  input wire enc_a,
  input wire enc_b,
  input wire enc_n,
  // motor configuration
  input wire [15:0] pole_pairs,
  // angles
  output reg [15:0] mech_angle,
  output reg [15:0] elec_angle
);

  ////////////////////////////////////////////////////////////////////////////
  // address decode

  function [7:0] reg_index;
    input [31:0] addr;
    begin
      reg_index = addr[9:2];
    end
  endfunction

  function mapped;
    input [31:0] addr;
    reg [7:0] idx;
    begin
      idx = addr[9:2];
      mapped = (addr[31:10] == 22'h000000) && (addr[1:0] == 2'h0) &&
        ((idx == `AED_IDX_MODE) || (idx == `AED_IDX_PPR) ||
         (idx == `AED_IDX_COUNT) || (idx == `AED_IDX_COUNT_N) ||
         (idx == `AED_IDX_OFFSETS) || (idx == `AED_IDX_ANGLES) ||
         (idx == `AED_IDX_MODE2));
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // quadrature and counting helpers

  // returns step and forward flags from previous and current a/b levels
  function [1:0] quad_decode;
    input [1:0] prev_ab;
    input [1:0] cur_ab;
    begin
      case ({prev_ab, cur_ab})
        4'h0: quad_decode = 2'h0;
        4'h1: quad_decode = 2'h3;
        4'h2: quad_decode = 2'h2;
        4'h3: quad_decode = 2'h0;
        4'h4: quad_decode = 2'h2;
        4'h5: quad_decode = 2'h0;
        4'h6: quad_decode = 2'h0;
        4'h7: quad_decode = 2'h3;
        4'h8: quad_decode = 2'h3;
        4'h9: quad_decode = 2'h0;
        4'ha: quad_decode = 2'h0;
        4'hb: quad_decode = 2'h2;
        4'hc: quad_decode = 2'h0;
        4'hd: quad_decode = 2'h2;
        4'he: quad_decode = 2'h3;
        4'hf: quad_decode = 2'h0;
        default: quad_decode = 2'h0;
      endcase
    end
  endfunction

  function [CNT_W-1:0] count_inc;
    input [CNT_W-1:0] cnt;
    input [CNT_W-1:0] last;
    begin
      if (cnt == last) begin
        count_inc = {CNT_W{1'b0}};
      end else begin
        count_inc = cnt + {{(CNT_W-1){1'b0}}, 1'b1};
      end
    end
  endfunction

  function [CNT_W-1:0] count_dec;
    input [CNT_W-1:0] cnt;
    input [CNT_W-1:0] last;
    begin
      if (cnt == {CNT_W{1'b0}}) begin
        count_dec = last;
      end else begin
        count_dec = cnt - {{(CNT_W-1){1'b0}}, 1'b1};
      end
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // registers

  reg [31:0] mode_reg;
  reg [31:0] mode2_reg;
  reg [CNT_W-1:0] ppr_reg;
  reg [CNT_W-1:0] count_reg;
  reg [CNT_W-1:0] count_n_reg;
  reg [31:0] offsets_reg;

  reg a_meta_reg;
  reg b_meta_reg;
  reg n_meta_reg;
  reg a_sync_reg;
  reg b_sync_reg;
  reg n_sync_reg;
  reg a_prev_reg;
  reg b_prev_reg;
  reg nq_prev_reg;

  reg [4:0] div_cnt_reg;
  reg [CNT_W:0] rem_reg;
  reg [CNT_W-1:0] div_ppr_reg;
  reg [15:0] quo_reg;

  ////////////////////////////////////////////////////////////////////////////
  // apb handshake

  wire bus_access;
  wire bus_done;
  wire wr_done;
  wire [7:0] idx;

  assign bus_access = psel && penable;
  assign bus_done = bus_access && pready;
  assign wr_done = bus_done && pwrite && mapped(paddr);
  assign idx = reg_index(paddr);

  wire wr_mode;
  wire wr_mode2;
  wire wr_ppr;
  wire wr_count;
  wire wr_count_n;
  wire wr_offsets;

  assign wr_mode = wr_done && (idx == `AED_IDX_MODE);
  assign wr_mode2 = wr_done && (idx == `AED_IDX_MODE2);
  assign wr_ppr = wr_done && (idx == `AED_IDX_PPR);
  assign wr_count = wr_done && (idx == `AED_IDX_COUNT);
  assign wr_count_n = wr_done && (idx == `AED_IDX_COUNT_N);
  assign wr_offsets = wr_done && (idx == `AED_IDX_OFFSETS);

  reg [31:0] rd_data;

  always @* begin
    rd_data = 32'h00000000;
    case (idx)
      `AED_IDX_MODE: rd_data = mode_reg;
      `AED_IDX_MODE2: rd_data = mode2_reg;
      `AED_IDX_PPR: rd_data = {8'h00, ppr_reg};
      `AED_IDX_COUNT: rd_data = {8'h00, count_reg};
      `AED_IDX_COUNT_N: rd_data = {8'h00, count_n_reg};
      `AED_IDX_OFFSETS: rd_data = offsets_reg;
      `AED_IDX_ANGLES: rd_data = {elec_angle, mech_angle};
      default: rd_data = 32'h00000000;
    endcase
  end

  // one wait state, then answer
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end else if (bus_access && !pready) begin
      pready <= 1'b1;
      pslverr <= !mapped(paddr) || (pwrite && (idx == `AED_IDX_ANGLES));
      if (!pwrite && mapped(paddr)) begin
        prdata <= rd_data;
      end else begin
        prdata <= 32'h00000000;
      end
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // configuration registers

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_reg <= `AED_RST_MODE;
      mode2_reg <= `AED_RST_MODE;
      ppr_reg <= `AED_RST_PPR;
      offsets_reg <= `AED_RST_OFFSETS;
    end else begin
      if (wr_mode) begin
        mode_reg <= pwdata & `AED_MODE_MASK;
      end
      if (wr_mode2) begin
        mode2_reg <= pwdata & `AED_MODE_MASK;
      end
      if (wr_ppr) begin
        ppr_reg <= pwdata[CNT_W-1:0];
      end
      if (wr_offsets) begin
        offsets_reg <= pwdata;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // input synchronisers and polarity

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      a_meta_reg <= 1'b0;
      b_meta_reg <= 1'b0;
      n_meta_reg <= 1'b0;
      a_sync_reg <= 1'b0;
      b_sync_reg <= 1'b0;
      n_sync_reg <= 1'b0;
    end else begin
      a_meta_reg <= enc_a;
      b_meta_reg <= enc_b;
      n_meta_reg <= enc_n;
      a_sync_reg <= a_meta_reg;
      b_sync_reg <= b_meta_reg;
      n_sync_reg <= n_meta_reg;
    end
  end

  wire a_in;
  wire b_in;
  wire n_in;
  wire nq_in;

  assign a_in = a_sync_reg ^ mode_reg[`AED_BIT_APOL];
  assign b_in = b_sync_reg ^ mode_reg[`AED_BIT_BPOL];
  assign n_in = n_sync_reg ^ mode_reg[`AED_BIT_NPOL];
  assign nq_in = n_in && (!mode_reg[`AED_BIT_INDEX_NEEDS_QUAD] || (a_in && b_in));

  ////////////////////////////////////////////////////////////////////////////
  // quadrature decode and counting

  wire [1:0] quad_flags;
  wire step;
  wire fwd;
  wire count_up;
  wire index_event;
  wire [CNT_W-1:0] ppr_m1;

  assign quad_flags = quad_decode({a_prev_reg, b_prev_reg}, {a_in, b_in});
  assign step = quad_flags[1];
  assign fwd = quad_flags[0];
  assign count_up = fwd ^ mode_reg[`AED_BIT_DIRECTION];
  assign index_event = nq_in && !nq_prev_reg;
  assign ppr_m1 = ppr_reg - {{(CNT_W-1){1'b0}}, 1'b1};

  reg [CNT_W-1:0] count_next;

  always @* begin
    count_next = count_reg;
    if (wr_count) begin
      count_next = pwdata[CNT_W-1:0];
    end else if (index_event && mode_reg[`AED_BIT_INDEX_LOADS]) begin
      count_next = count_n_reg;
    end else if (step) begin
      if (count_up) begin
        count_next = count_inc(count_reg, ppr_m1);
      end else begin
        count_next = count_dec(count_reg, ppr_m1);
      end
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      a_prev_reg <= 1'b0;
      b_prev_reg <= 1'b0;
      nq_prev_reg <= 1'b0;
      count_reg <= `AED_RST_COUNT;
      count_n_reg <= `AED_RST_COUNT;
    end else begin
      a_prev_reg <= a_in;
      b_prev_reg <= b_in;
      nq_prev_reg <= nq_in;
      count_reg <= count_next;
      if (wr_count_n) begin
        count_n_reg <= pwdata[CNT_W-1:0];
      end else if (index_event && !mode_reg[`AED_BIT_INDEX_LOADS]) begin
        count_n_reg <= count_reg;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // angle computation, one quotient bit per cycle

  wire [CNT_W:0] rem_shift;
  wire rem_ge;
  wire [15:0] quo_final;
  wire [15:0] mech_next;
  wire [31:0] elec_prod;

  assign rem_shift = {rem_reg[CNT_W-1:0], 1'b0};
  assign rem_ge = (rem_shift >= {1'b0, div_ppr_reg});
  assign quo_final = {quo_reg[14:0], rem_ge};
  assign mech_next = ((div_ppr_reg == {CNT_W{1'b0}}) ? 16'h0000 : quo_final) +
    offsets_reg[15:0];
  assign elec_prod = mech_next * pole_pairs;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_cnt_reg <= 5'h00;
      rem_reg <= {(CNT_W+1){1'b0}};
      div_ppr_reg <= {CNT_W{1'b0}};
      quo_reg <= 16'h0000;
      mech_angle <= 16'h0000;
      elec_angle <= 16'h0000;
    end else if (div_cnt_reg == 5'h00) begin
      rem_reg <= {1'b0, count_reg};
      div_ppr_reg <= ppr_reg;
      quo_reg <= 16'h0000;
      div_cnt_reg <= `AED_DIV_STEPS;
    end else begin
      rem_reg <= rem_ge ? (rem_shift - {1'b0, div_ppr_reg}) : rem_shift;
      quo_reg <= quo_final;
      div_cnt_reg <= div_cnt_reg - 5'h01;
      if (div_cnt_reg == 5'h01) begin
        mech_angle <= mech_next;
        elec_angle <= elec_prod[15:0] + offsets_reg[31:16];
      end
    end
  end

endmodule

// >>> hw/aed_map.vh
// register map, field positions and reset values of the quadrature encoder decoder
// assumes a 32-bit apb slave; byte address is four times the register index
//
// Contract
// - the a input is inverted when the a polarity bit (bit 0) of the mode register is set.
// - the b input is inverted when the b polarity bit (bit 1) of the mode register is set.
// - the index input is inverted when the index polarity bit (bit 2) is set.
// - with bit 3 clear the index is n alone, with it set the index needs n, a and b together.
// - on an index event bit 8 clear copies live count to the latched count, set loads back.
// - the 24-bit step count wraps modulo pulses per revolution; bit 12 set counts negative.
// - a writable 24-bit pulses-per-revolution value sets the modulus and the angle scale.
// - software may write the live count and counting goes on from the written value.
// - a 24-bit latched count holds the step count captured at the latest index event; with bit 8 set index events leave it unchanged.
// - a signed 16-bit mechanical offset in the low half rotates the mechanical angle.
// - a signed 16-bit electrical offset in the high half rotates the electrical angle.
// - mechanical angle is count times 2^16 over pulses per revolution plus offset.
// - electrical angle is mechanical angle times pole pairs plus offset, read only.
// - the pole-pair count is an unsigned 16-bit value supplied from outside the block.
`ifndef AED_MAP_VH
`define AED_MAP_VH

// register indices
`define AED_IDX_MODE 8'h25
`define AED_IDX_PPR 8'h26
`define AED_IDX_COUNT 8'h27
`define AED_IDX_COUNT_N 8'h28
`define AED_IDX_OFFSETS 8'h29
`define AED_IDX_ANGLES 8'h2a
`define AED_IDX_MODE2 8'h2c

// mode register fields
`define AED_BIT_APOL 0
`define AED_BIT_BPOL 1
`define AED_BIT_NPOL 2
`define AED_BIT_INDEX_NEEDS_QUAD 3
`define AED_BIT_INDEX_LOADS 8
`define AED_BIT_DIRECTION 12
`define AED_MODE_MASK 32'h0000110f

// reset values
`define AED_RST_MODE 32'h00000000
`define AED_RST_PPR 24'h000000
`define AED_RST_COUNT 24'h000000
`define AED_RST_OFFSETS 32'h00000000

// angle divider steps
`define AED_DIV_STEPS 5'h10

`endif

// >>> tb/aed_decoder_chk.sv
// port assertions for the quadrature decoder
// assumes bind into aed_decoder, pclk domain only
`timescale 1ns/1ps
`include "aed_map.vh"
module aed_chk (
  // apb
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] paddr,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  // angles
  input wire [15:0] mech_angle
);
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  wire rd_ok = pready && !pwrite;
  //////////////////////////////
  ready_wait_a: assert property (psel && penable && !pready |=> pready)
    else $error("no ready");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("ready too long");
  idle_data_a: assert property (!pready |-> prdata == 32'h0)
    else $error("stray read data");
  err_framed_a: assert property (pslverr |-> pready && psel && penable)
    else $error("stray error");
  angles_ro_a: assert property (pready && pwrite && paddr == 32'ha8 |-> pslverr)
    else $error("angle write accepted");
  mode_mask_a: assert property (rd_ok && paddr == 32'h94 |-> !pslverr &&
    (prdata & ~`AED_MODE_MASK) == 32'h0) else $error("mode bits leak");
  count_width_a: assert property (rd_ok && paddr == 32'h9c |-> prdata[31:24] == 8'h0)
    else $error("count too wide");
  angle_hold_a: assert property ($changed(mech_angle) |=> $stable(mech_angle) [*8])
    else $error("angle jitter");
  cover property (pready && pslverr);
  cover property (rd_ok && paddr == 32'ha8);
  cover property ($changed(mech_angle));
endmodule
bind aed_decoder aed_chk chk_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .prdata,
  .pready, .pslverr, .mech_angle);

// >>> tb/aed_enc_model.sv
// quadrature encoder with index line, stepped by bench tasks
// assumes one clock; lines change just after a rising edge
`timescale 1ns/1ps
module aed_enc_model (
  // clock
  input wire clk,
  // encoder lines
  output logic enc_a,
  output logic enc_b,
  output logic enc_n
);
  logic [1:0] ph = 2'h0;
  initial enc_n = 1'b0;
  // gray order, one line per step
  always_comb begin
    enc_a = ph[1];
    enc_b = ph[1] ^ ph[0];
  end
  task step(input bit up);
    @(posedge clk);
    ph <= up ? ph + 2'h1 : ph - 2'h1;
    repeat (4) @(posedge clk);
  endtask
  task set_n(input bit v);
    @(posedge clk);
    enc_n <= v;
    repeat (5) @(posedge clk);
  endtask
endmodule

// >>> tb/testbench.sv
// self-checking bench for the quadrature decoder
// assumes aed_decoder, aed_enc_model and aed_chk compiled first
`timescale 1ns/1ps
`include "aed_map.vh"
module testbench;
  logic pclk = 1'b0;
  logic presetn, psel, penable, pwrite;
  logic [31:0] paddr, pwdata, prdata, rv;
  logic pready, pslverr, enc_a, enc_b, enc_n, ev;
  logic [15:0] pole_pairs, mech_angle, elec_angle;
  int n_errors = 0, samples_checked = 0;
  localparam logic [31:0] A_MODE = 4 * `AED_IDX_MODE, A_PPR = 4 * `AED_IDX_PPR;
  localparam logic [31:0] A_CNT = 4 * `AED_IDX_COUNT, A_CNTN = 4 * `AED_IDX_COUNT_N;
  localparam logic [31:0] A_OFS = 4 * `AED_IDX_OFFSETS, A_ANG = 4 * `AED_IDX_ANGLES;
  localparam logic [31:0] A_MODE2 = 4 * `AED_IDX_MODE2;
  always #2 pclk = ~pclk;
  aed_decoder dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .enc_a, .enc_b, .enc_n, .pole_pairs, .mech_angle, .elec_angle);
  aed_enc_model enc_u (.clk(pclk), .enc_a, .enc_b, .enc_n);
  //////////////////////////////
  task chk(input string nm, input logic [31:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task apb(input logic w, input logic [31:0] a, d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rv = prdata;
    ev = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wr(input logic [31:0] a, d);
    apb(1'b1, a, d);
  endtask
  task rc(input logic [31:0] a, exp, input string nm);
    apb(1'b0, a, 32'h0);
    chk(nm, rv, exp);
  endtask
  task settle;
    repeat (6) @(posedge pclk);
  endtask
  task steps(input int k);
    repeat (k) enc_u.step(1'b1);
  endtask
  task pulse_n;
    enc_u.set_n(1'b1);
    enc_u.set_n(1'b0);
  endtask
  task tally_and_finish;
    if (n_errors == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  //////////////////////////////
  initial begin
    presetn <= 1'b0;
    psel <= 1'b0;
    penable <= 1'b0;
    pwrite <= 1'b0;
    paddr <= 32'h0;
    pwdata <= 32'h0;
    pole_pairs <= 16'h0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    settle;
    rc(A_MODE, 32'h0, "mode");
    rc(A_PPR, 32'h0, "ppr");
    rc(A_CNT, 32'h0, "count");
    rc(A_CNTN, 32'h0, "count_n");
    rc(A_OFS, 32'h0, "offsets");
    apb(1'b0, 32'h100, 32'h0);
    chk("unmapped err", ev, 32'h1);
    wr(A_MODE, 32'hffffffff);
    rc(A_MODE, `AED_MODE_MASK, "mode mask");
    wr(A_MODE2, 32'hffffffff);
    rc(A_MODE2, `AED_MODE_MASK, "mode2");
    wr(A_MODE, 32'h0);
    wr(A_PPR, 32'h8);
    rc(A_PPR, 32'h8, "ppr");
    wr(A_CNT, 32'h6);
    steps(3);
    rc(A_CNT, 32'h1, "wrap up");
    wr(A_MODE, 32'h1000);
    steps(2);
    rc(A_CNT, 32'h7, "wrap down");
    wr(A_MODE, 32'h1);
    settle;
    wr(A_CNT, 32'h4);
    steps(2);
    rc(A_CNT, 32'h2, "a inverted");
    wr(A_MODE, 32'h2);
    settle;
    wr(A_CNT, 32'h4);
    steps(2);
    rc(A_CNT, 32'h2, "b inverted");
    wr(A_MODE, 32'h0);
    settle;
    wr(A_CNT, 32'h3);
    enc_u.set_n(1'b1);
    steps(1);
    enc_u.set_n(1'b0);
    rc(A_CNTN, 32'h3, "latch");
    wr(A_MODE, 32'h4);
    settle;
    wr(A_CNTN, 32'h55);
    enc_u.set_n(1'b1);
    rc(A_CNTN, 32'h55, "n high inverted");
    steps(1);
    enc_u.set_n(1'b0);
    rc(A_CNTN, 32'h5, "n low inverted");
    wr(A_MODE, 32'h8);
    settle;
    wr(A_CNTN, 32'h11);
    pulse_n;
    rc(A_CNTN, 32'h11, "index gated");
    steps(3);
    wr(A_CNT, 32'h2);
    pulse_n;
    rc(A_CNTN, 32'h2, "index qualified");
    wr(A_MODE, 32'h100);
    wr(A_CNTN, 32'h6);
    pulse_n;
    rc(A_CNT, 32'h6, "reload");
    wr(A_CNTN, 32'h0);
    steps(1);
    pulse_n;
    rc(A_CNT, 32'h0, "reload zero");
    rc(A_CNTN, 32'h0, "cleared latch");
    wr(A_MODE, 32'h0);
    wr(A_CNT, 32'h2);
    wr(A_OFS, 32'h00100100);
    pole_pairs <= 16'h3;
    repeat (60) @(posedge pclk);
    chk("mech", mech_angle, 32'h4100);
    chk("elec", elec_angle, 32'hc310);
    rc(A_ANG, 32'hc3104100, "angles");
    wr(A_ANG, 32'h0);
    chk("ro err", ev, 32'h1);
    rc(A_ANG, 32'hc3104100, "angles kept");
    tally_and_finish;
  end
  initial begin
    repeat (20000) @(posedge pclk);
    n_errors++;
    tally_and_finish;
  end
endmodule
